/* verilog/jpa_pkg.sv */
/*
 * shared constants for the probe access block: tap state codes, instruction
 * codes, pin positions and default sizes.
 * assumes a standard four-wire test port plus an optional test-reset pin.
 */
package jpa_pkg;
    // ==========================================================
    // instruction register
    localparam int IR_W = 4;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] IR_BYPASS = 4'hf;
    localparam logic [3:0] IR_PROBE_SEL = 4'h8;
    // ==========================================================
    // pin positions inside the five-pin vectors
    localparam int N_PINS = 5;
    localparam int PIN_PROBE_OUT_A = 0;
    localparam int PIN_PROBE_OUT_B = 1;
    localparam int PIN_TDI = 2;
    localparam int PIN_TCK = 3;
    localparam int PIN_TDO = 4;
    // ==========================================================
    // sizes
    localparam int DEF_NETS = 16;
    localparam int SYNC_STAGES = 2;
    // ==========================================================
    // tap controller states, one-hot
    typedef enum logic [15:0] {
        TAP_TLR = 16'h0001,
        TAP_RTI = 16'h0002,
        TAP_SELDR = 16'h0004,
        TAP_CAPDR = 16'h0008,
        TAP_SHDR = 16'h0010,
        TAP_EX1DR = 16'h0020,
        TAP_PSDR = 16'h0040,
        TAP_EX2DR = 16'h0080,
        TAP_UPDR = 16'h0100,
        TAP_SELIR = 16'h0200,
        TAP_CAPIR = 16'h0400,
        TAP_SHIR = 16'h0800,
        TAP_EX1IR = 16'h1000,
        TAP_PSIR = 16'h2000,
        TAP_EX2IR = 16'h4000,
        TAP_UPIR = 16'h8000
    } jpa_tap_e;
endpackage : jpa_pkg

/* verilog/jpa_sync.sv */
/*
 * plain two-stage level synchroniser, W bits wide.
 * assumes each bit is a slow level; multi-bit words must not use it.
 */
module jpa_sync import jpa_pkg::*; #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule : jpa_sync

/* verilog/jpa_xfer.sv */
/*
 * word crossing by toggle handshake: src_load latches a word and flips a
 * toggle; the destination catches the word once the toggle edge arrives.
 * assumes loads are further apart than three destination clocks.
 */
module jpa_xfer import jpa_pkg::*; #(
    parameter int W = 8
) (
    input wire logic src_clk,
    input wire logic src_rst_n,
    input wire logic src_load,
    input wire logic [W-1:0] src_data,
    input wire logic dst_clk,
    input wire logic dst_rst_n,
    output logic [W-1:0] dst_data
);
    logic [W-1:0] hold;
    logic [W-1:0] next_hold;
    logic tog;
    logic next_tog;
    logic t1;
    logic t2;
    logic t3;
    logic [W-1:0] next_dst_data;

    // ==========================================================
    // source side
    always_comb begin
        next_hold = src_load ? src_data : hold;
        next_tog = src_load ? ~tog : tog;
    end

    always_ff @(posedge src_clk or negedge src_rst_n) begin
        if (!src_rst_n) begin
            hold <= '0;
            tog <= 1'b0;
        end else begin
            hold <= next_hold;
            tog <= next_tog;
        end
    end

    // ==========================================================
    // destination side; hold is stable whenever the edge is seen
    always_comb begin
        next_dst_data = (t2 ^ t3) ? hold : dst_data;
    end

    always_ff @(posedge dst_clk or negedge dst_rst_n) begin
        if (!dst_rst_n) begin
            t1 <= 1'b0;
            t2 <= 1'b0;
            t3 <= 1'b0;
            dst_data <= '0;
        end else begin
            t1 <= tog;
            t2 <= t1;
            t3 <= t2;
            dst_data <= next_dst_data;
        end
    end
endmodule : jpa_xfer

/* verilog/jpa_probe_access.sv */
/*
 * probe access control: test access port on tck, probe net selection,
 * and the pad muxing of the two probe pins and the tdi/tck/tdo pins.
 * assumes probe_nets and user_* come from logic on ref_clk, pins from outside,
 * and that trst_reserved, jtag_dedicated and fuse_secured are static straps.
 */
module jpa_probe_access import jpa_pkg::*; #(
    parameter int NETS = DEF_NETS
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic trst_n_pin,
    input wire logic trst_reserved,
    input wire logic jtag_dedicated,
    input wire logic fuse_secured,
    input wire logic [NETS-1:0] probe_nets,
    input wire logic [N_PINS-1:0] pin_i,
    output logic [N_PINS-1:0] pin_o,
    output logic [N_PINS-1:0] pin_oe_n,
    input wire logic [N_PINS-1:0] user_o,
    input wire logic [N_PINS-1:0] user_oe_n,
    output logic [N_PINS-1:0] user_i,
    output logic probe_en
);
    localparam int SEL_W = $clog2(NETS);
    localparam int DR_W = 2 * SEL_W;
    function automatic logic is_probe_pin(input int k);
        is_probe_pin = (k == PIN_PROBE_OUT_A) || (k == PIN_PROBE_OUT_B);
    endfunction : is_probe_pin
    // ==========================================================
    // tck domain reset
    logic trst_eff;
    logic tck_rst_n;
    assign trst_eff = trst_n_pin | ~trst_reserved;
    assign tck_rst_n = arst_n & trst_eff & ~fuse_secured;
    // ==========================================================
    // tap state machine
    jpa_tap_e state;
    jpa_tap_e next_state;
    logic tap_active;
    logic next_tap_active;
    always_comb begin
        case (state)
            TAP_TLR: next_state = tms ? TAP_TLR : TAP_RTI;
            TAP_RTI: next_state = tms ? TAP_SELDR : TAP_RTI;
            TAP_SELDR: next_state = tms ? TAP_SELIR : TAP_CAPDR;
            TAP_CAPDR: next_state = tms ? TAP_EX1DR : TAP_SHDR;
            TAP_SHDR: next_state = tms ? TAP_EX1DR : TAP_SHDR;
            TAP_EX1DR: next_state = tms ? TAP_UPDR : TAP_PSDR;
            TAP_PSDR: next_state = tms ? TAP_EX2DR : TAP_PSDR;
            TAP_EX2DR: next_state = tms ? TAP_UPDR : TAP_SHDR;
            TAP_UPDR: next_state = tms ? TAP_SELDR : TAP_RTI;
            TAP_SELIR: next_state = tms ? TAP_TLR : TAP_CAPIR;
            TAP_CAPIR: next_state = tms ? TAP_EX1IR : TAP_SHIR;
            TAP_SHIR: next_state = tms ? TAP_EX1IR : TAP_SHIR;
            TAP_EX1IR: next_state = tms ? TAP_UPIR : TAP_PSIR;
            TAP_PSIR: next_state = tms ? TAP_EX2IR : TAP_PSIR;
            TAP_EX2IR: next_state = tms ? TAP_UPIR : TAP_SHIR;
            TAP_UPIR: next_state = tms ? TAP_SELDR : TAP_RTI;
            default: next_state = TAP_TLR;
        endcase
        // registered so the crossing sees a single clean bit
        next_tap_active = (next_state != TAP_TLR);
    end
    // ==========================================================
    // instruction and data registers
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] next_ir;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] next_ir_sh;
    logic [DR_W-1:0] dr_sh;
    logic [DR_W-1:0] next_dr_sh;
    logic byp;
    logic next_byp;
    logic sel_load;
    logic tdi;

    assign tdi = pin_i[PIN_TDI];

    always_comb begin
        next_ir = ir;
        next_ir_sh = ir_sh;
        next_dr_sh = dr_sh;
        next_byp = byp;
        case (state)
            TAP_TLR: next_ir = IR_BYPASS;
            TAP_CAPIR: next_ir_sh = IR_CAPTURE;
            TAP_SHIR: next_ir_sh = {tdi, ir_sh[IR_W-1:1]};
            TAP_UPIR: next_ir = ir_sh;
            TAP_CAPDR: begin
                next_dr_sh = '0;
                next_byp = 1'b0;
            end
            TAP_SHDR: begin
                if (ir == IR_PROBE_SEL) begin
                    next_dr_sh = {tdi, dr_sh[DR_W-1:1]};
                end else begin
                    next_byp = tdi;
                end
            end
            default: next_ir = ir;
        endcase
    end

    assign sel_load = (state == TAP_UPDR) && (ir == IR_PROBE_SEL);

    always_ff @(posedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            state <= TAP_TLR;
            tap_active <= 1'b0;
            ir <= IR_BYPASS;
            ir_sh <= '0;
            dr_sh <= '0;
            byp <= 1'b0;
        end else begin
            state <= next_state;
            tap_active <= next_tap_active;
            ir <= next_ir;
            ir_sh <= next_ir_sh;
            dr_sh <= next_dr_sh;
            byp <= next_byp;
        end
    end
    // ==========================================================
    // tdo launches on the falling edge, as the pod expects
    logic tdo_q;
    logic next_tdo_q;
    logic tdo_en;
    logic next_tdo_en;

    always_comb begin
        next_tdo_en = (state == TAP_SHIR) || (state == TAP_SHDR);
        if (state == TAP_SHIR) begin
            next_tdo_q = ir_sh[0];
        end else if (ir == IR_PROBE_SEL) begin
            next_tdo_q = dr_sh[0];
        end else begin
            next_tdo_q = byp;
        end
    end

    always_ff @(negedge tck or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            tdo_q <= 1'b0;
            tdo_en <= 1'b0;
        end else begin
            tdo_q <= next_tdo_q;
            tdo_en <= next_tdo_en;
        end
    end
    // ==========================================================
    // crossings into ref_clk
    logic [1:0] lvl_s;
    logic active_s;
    logic trst_s;
    logic [N_PINS-1:0] pin_s;
    logic [DR_W-1:0] sel;

    jpa_sync #(.W(2)) u_lvl_sync (
        .clk(ref_clk),
        .arst_n(arst_n),
        .d({tap_active, trst_n_pin}),
        .q(lvl_s)
    );
    assign active_s = lvl_s[1];
    assign trst_s = lvl_s[0];

    jpa_sync #(.W(N_PINS)) u_pin_sync (
        .clk(ref_clk),
        .arst_n(arst_n),
        .d(pin_i),
        .q(pin_s)
    );

    jpa_xfer #(.W(DR_W)) u_sel_xfer (
        .src_clk(tck),
        .src_rst_n(tck_rst_n),
        .src_load(sel_load),
        .src_data(dr_sh),
        .dst_clk(ref_clk),
        .dst_rst_n(arst_n),
        .dst_data(sel)
    );
    // ==========================================================
    // pad control on ref_clk
    logic trst_ok;
    logic allow;
    logic next_probe_en;
    logic jtag_q;
    logic next_jtag;
    logic [N_PINS-1:0] pick;
    logic [N_PINS-1:0] pin_o_q;
    logic [N_PINS-1:0] next_pin_o;
    logic [N_PINS-1:0] pin_oe_n_q;
    logic [N_PINS-1:0] next_pin_oe_n;
    logic [N_PINS-1:0] next_user_i;

    always_comb begin
        trst_ok = ~trst_reserved | trst_s;
        allow = trst_ok & ~fuse_secured;
        next_probe_en = allow & active_s;
        // dedicated keeps jtag, flexible follows tap
        next_jtag = allow & (jtag_dedicated | active_s);
        pick = '0;
        pick[PIN_PROBE_OUT_A] = probe_nets[sel[SEL_W-1:0]];
        pick[PIN_PROBE_OUT_B] = probe_nets[sel[DR_W-1:SEL_W]];
    end

    for (genvar k = 0; k < N_PINS; k++) begin : g_pin
        logic user_ok;
        always_comb begin
            if (is_probe_pin(k)) begin
                // probe pins fall back to user when not probing and not fuse secured
                user_ok = ~fuse_secured & ~next_probe_en;
                next_pin_o[k] = user_ok ? user_o[k] : (next_probe_en & pick[k]);
                next_pin_oe_n[k] = user_ok ? user_oe_n[k] : ~next_probe_en;
            end else begin
                // tdi/tck/tdo serve the user design only when not dedicated, not claimed by jtag and not fuse secured
                user_ok = ~fuse_secured & ~jtag_dedicated & ~next_jtag;
                next_pin_o[k] = user_ok & user_o[k];
                next_pin_oe_n[k] = user_ok ? user_oe_n[k] : 1'b1;
            end
            // block inputs while pin is claimed
            next_user_i[k] = user_ok & pin_s[k];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            probe_en <= 1'b0;
            jtag_q <= 1'b0;
            pin_o_q <= '0;
            pin_oe_n_q <= '1;
            user_i <= '0;
        end else begin
            probe_en <= next_probe_en;
            jtag_q <= next_jtag;
            pin_o_q <= next_pin_o;
            pin_oe_n_q <= next_pin_oe_n;
            user_i <= next_user_i;
        end
    end

    // tdo stays in tck timing; only its owner select comes from ref_clk
    always_comb begin
        pin_o = pin_o_q;
        pin_oe_n = pin_oe_n_q;
        if (jtag_q) begin
            pin_o[PIN_TDO] = tdo_q;
            pin_oe_n[PIN_TDO] = ~tdo_en;
        end
    end
    // ==========================================================
    // checks, tck domain
    property p_trst_holds_tlr;
        @(posedge tck) disable iff (!arst_n)
        (trst_reserved && !trst_n_pin) |-> (state == TAP_TLR);
    endproperty
    a_trst_holds_tlr: assert property (p_trst_holds_tlr) else $error("tap left reset with test-reset low");
    property p_fuse_holds_tlr;
        @(posedge tck) disable iff (!arst_n)
        fuse_secured |-> (state == TAP_TLR) && !tdo_en;
    endproperty
    a_fuse_holds_tlr: assert property (p_fuse_holds_tlr) else $error("tap active with fuse secured");
    property p_leave_tlr;
        @(posedge tck) disable iff (!tck_rst_n)
        (state == TAP_TLR && !tms) |=> (state == TAP_RTI) && tap_active;
    endproperty
    a_leave_tlr: assert property (p_leave_tlr) else $error("tms low did not leave reset");
    property p_five_tms;
        @(posedge tck) disable iff (!tck_rst_n)
        tms [*5] |=> (state == TAP_TLR) && !tap_active;
    endproperty
    a_five_tms: assert property (p_five_tms) else $error("five tms high did not reset tap");
    // ==========================================================
    // checks, ref_clk domain
    property p_trst_gate;
        @(posedge ref_clk) disable iff (!arst_n)
        (trst_reserved && !trst_s) |=> !probe_en
            && (user_i[PIN_PROBE_OUT_A] == ($past(pin_s[PIN_PROBE_OUT_A]) && !$past(fuse_secured)));
    endproperty
    a_trst_gate: assert property (p_trst_gate) else $error("probe on with test-reset low");
    property p_fuse_secure;
        @(posedge ref_clk) disable iff (!arst_n)
        fuse_secured [*2] |-> (&pin_oe_n) && !probe_en && (user_i == '0);
    endproperty
    a_fuse_secure: assert property (p_fuse_secure) else $error("pins not secured with fuse");
    property p_unreserved;
        @(posedge ref_clk) disable iff (!arst_n)
        (!trst_reserved && !fuse_secured && active_s) |=> probe_en;
    endproperty
    a_unreserved: assert property (p_unreserved) else $error("unreserved test-reset blocked probe");
    property p_enter_probe;
        @(posedge ref_clk) disable iff (!arst_n)
        ($rose(active_s) && allow) |=> probe_en && !pin_oe_n[PIN_PROBE_OUT_A] && !pin_oe_n[PIN_PROBE_OUT_B];
    endproperty
    a_enter_probe: assert property (p_enter_probe) else $error("probe pins not driven after reset exit");
    property p_user_io;
        @(posedge ref_clk) disable iff (!arst_n)
        (!next_probe_en && !fuse_secured) |=> pin_oe_n[PIN_PROBE_OUT_A] == $past(user_oe_n[PIN_PROBE_OUT_A]);
    endproperty
    a_user_io: assert property (p_user_io) else $error("probe pin not returned to user");
    property p_route;
        @(posedge ref_clk) disable iff (!arst_n)
        next_probe_en |=> pin_o[PIN_PROBE_OUT_B] == $past(probe_nets[sel[DR_W-1:SEL_W]]);
    endproperty
    a_route: assert property (p_route) else $error("probe pin does not carry selected net");
    property p_block_input;
        @(posedge ref_clk) disable iff (!arst_n)
        probe_en |-> !user_i[PIN_PROBE_OUT_A] && !user_i[PIN_PROBE_OUT_B];
    endproperty
    a_block_input: assert property (p_block_input) else $error("user input leaked during probing");
endmodule : jpa_probe_access

/* tb/jpa_pod.sv */
/*
 * behavioural probe pod: walks the test access port to pick the probed nets.
 * assumes tdo is the resolved pad level; tck stands still between frames.
 */
module jpa_pod import jpa_pkg::*; (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 100ps;
    // about 180 ns: covers the two-flop sync and pad register on ref_clk
    localparam int OWN_WAIT = 30;
    // ==========================================================
    // idle levels: tms and tdi rest high, as the pull-ups leave them
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // ==========================================================
    // one tck period of 6 ns; tdo is taken just before the rise
    task automatic stp(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #3;
        q = tdo;
        tck = 1'b1;
        #3;
        tck = 1'b0;
    endtask : stp
    task automatic reset_tap();
        logic q;
        repeat (5) stp(1'b1, 1'b1, q);
    endtask : reset_tap
    // select nets through ir and dr
    task automatic load(input logic [3:0] a, input logic [3:0] b, output logic [3:0] cap_ir,
                        output logic [7:0] cap_dr);
        logic q;
        logic [7:0] dr;
        dr = {b, a};
        stp(1'b0, 1'b1, q);
        // idle until the pins change owner on ref_clk
        repeat (OWN_WAIT) stp(1'b0, 1'b1, q);
        stp(1'b1, 1'b1, q);
        stp(1'b1, 1'b1, q);
        stp(1'b0, 1'b1, q);
        stp(1'b0, 1'b1, q);
        for (int i = 0; i < 4; i++) begin
            stp(i == 3, IR_PROBE_SEL[i], cap_ir[i]);
        end
        stp(1'b1, 1'b1, q);
        stp(1'b1, 1'b1, q);
        stp(1'b0, 1'b1, q);
        stp(1'b0, 1'b1, q);
        for (int i = 0; i < 8; i++) begin
            stp(i == 7, dr[i], cap_dr[i]);
        end
        stp(1'b1, 1'b1, q);
        stp(1'b0, 1'b1, q);
        tms = 1'b1;
        tdi = 1'b1;
    endtask : load
endmodule : jpa_pod

/* tb/tb_jpa_probe_access.sv */
/*
 * self-checking bench for the probe access block with the pod model.
 * assumes straps change only between scenarios, driven on ref_clk.
 */
module tb_jpa_probe_access import jpa_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, arst_n, trst_n_pin, trst_reserved, jtag_dedicated, fuse_secured, probe_en;
    logic [15:0] probe_nets;
    logic [4:0] pin_i, pin_o, pin_oe_n, user_o, user_oe_n, user_i, ext;
    logic [3:0] cap_ir;
    logic [7:0] cap_dr;
    wire tck, tms, tdi;
    int err_count, compares;
    // ==========================================================
    // pads: whoever enables drives; tdi and tck come from the pod
    assign pin_i = {pin_oe_n[4] ? ext[4] : pin_o[4], tck, tdi,
                    pin_oe_n[1] ? ext[1] : pin_o[1], pin_oe_n[0] ? ext[0] : pin_o[0]};
    jpa_probe_access i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .tck(tck), .tms(tms),
        .trst_n_pin(trst_n_pin), .trst_reserved(trst_reserved), .jtag_dedicated(jtag_dedicated),
        .fuse_secured(fuse_secured), .probe_nets(probe_nets), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_n(pin_oe_n), .user_o(user_o), .user_oe_n(user_oe_n), .user_i(user_i),
        .probe_en(probe_en));
    jpa_pod i_pod (.tck(tck), .tms(tms), .tdi(tdi), .tdo(pin_i[4]));
    always #20 ref_clk = ~ref_clk;
    // ==========================================================
    // helpers
    task automatic chk(input logic [4:0] got, input logic [4:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    // sample at the falling edge so the rising edge updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : cyc
    task automatic straps(input logic rsv, input logic ded, input logic fuse, input logic trst);
        @(posedge ref_clk);
        trst_reserved <= rsv;
        jtag_dedicated <= ded;
        fuse_secured <= fuse;
        trst_n_pin <= trst;
        cyc(6);
    endtask : straps
    task automatic results();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    // ==========================================================
    // scenarios
    task automatic t_reset_user();
        cyc(4);
        chk({4'h0, probe_en}, 5'h00, "probe on after reset");
        chk(pin_o, user_o, "user drive");
        chk(pin_oe_n, user_oe_n, "user enable");
        chk(user_i, 5'h17, "user input path");
    endtask : t_reset_user
    task automatic t_probe_flex();
        straps(1'b1, 1'b0, 1'b0, 1'b1);
        i_pod.load(4'h3, 4'hc, cap_ir, cap_dr);
        chk({1'b0, cap_ir}, 5'h01, "ir capture");
        chk(cap_dr[4:0], 5'h00, "dr capture");
        cyc(8);
        chk({4'h0, probe_en}, 5'h01, "probe off");
        chk(pin_oe_n, 5'h1c, "probe pin enables");
        chk(user_i, 5'h00, "user inputs leak");
        @(posedge ref_clk);
        probe_nets <= 16'h1008;
        cyc(3);
        chk({3'h0, pin_o[1:0]}, 5'h03, "probe pick high");
        @(posedge ref_clk);
        probe_nets <= 16'heff7;
        cyc(3);
        chk({3'h0, pin_o[1:0]}, 5'h00, "probe pick low");
        cyc(6);
        i_pod.load(4'hf, 4'h0, cap_ir, cap_dr);
        @(posedge ref_clk);
        probe_nets <= 16'h8000;
        cyc(8);
        chk({3'h0, pin_o[1:0]}, 5'h01, "probe pick edge fields");
    endtask : t_probe_flex
    task automatic t_tap_reset();
        i_pod.reset_tap();
        cyc(8);
        chk({4'h0, probe_en}, 5'h00, "probe kept");
        chk(pin_oe_n, user_oe_n, "pins not returned");
        chk(pin_o, user_o, "drive not returned");
    endtask : t_tap_reset
    task automatic t_trst_ded();
        straps(1'b1, 1'b1, 1'b0, 1'b0);
        i_pod.load(4'h1, 4'h2, cap_ir, cap_dr);
        cyc(8);
        chk({4'h0, probe_en}, 5'h00, "probe with trst low");
        chk(pin_oe_n, {3'b111, user_oe_n[1:0]}, "dedicated trst low pins");
        chk(user_i & 5'h1c, 5'h00, "jtag pins as user");
        straps(1'b1, 1'b1, 1'b0, 1'b1);
        i_pod.load(4'h1, 4'h2, cap_ir, cap_dr);
        cyc(8);
        chk({4'h0, probe_en}, 5'h01, "dedicated probe off");
        chk(pin_oe_n & 5'h0f, 5'h0c, "dedicated probe pins");
    endtask : t_trst_ded
    task automatic t_trst_unreserved();
        i_pod.reset_tap();
        straps(1'b0, 1'b0, 1'b0, 1'b0);
        i_pod.load(4'h5, 4'h6, cap_ir, cap_dr);
        cyc(8);
        chk({4'h0, probe_en}, 5'h01, "unreserved trst blocks");
        chk({1'b0, cap_ir}, 5'h01, "unreserved ir capture");
    endtask : t_trst_unreserved
    task automatic t_fuse();
        straps(1'b0, 1'b0, 1'b1, 1'b1);
        chk(pin_oe_n, 5'h1f, "secured pins driven");
        chk(user_i, 5'h00, "secured inputs pass");
        i_pod.load(4'h5, 4'h6, cap_ir, cap_dr);
        cyc(8);
        chk({4'h0, probe_en}, 5'h00, "secured probe on");
        chk(pin_oe_n, 5'h1f, "secured after walk");
    endtask : t_fuse
    // ==========================================================
    // main sequence and watchdog
    initial begin
        ref_clk = 1'b0;
        arst_n = 1'b0;
        trst_n_pin = 1'b0;
        trst_reserved = 1'b1;
        jtag_dedicated = 1'b0;
        fuse_secured = 1'b0;
        probe_nets = 16'h0000;
        user_o = 5'h15;
        user_oe_n = 5'h0a;
        ext = 5'h02;
        err_count = 0;
        compares = 0;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_reset_user();
        t_probe_flex();
        t_tap_reset();
        t_trst_ded();
        t_trst_unreserved();
        t_fuse();
        results();
    end
    initial begin
        #50000;
        err_count++;
        results();
    end
endmodule : tb_jpa_probe_access
